//--- rtl/ivc_pkg.sv
// Shared constants and carrier types for the invalid-operation, invalid-address
// and operand store/fetch error indication block.
// Assumes a single 100 MHz clock and an APB master with 32-bit data.
package ivc_pkg;

    // Register byte offsets on the APB bus
    localparam logic [31:0] IVC_ADDR_IND   = 32'h0000_0000; // Sticky indicator bits, write one to clear
    localparam logic [31:0] IVC_ADDR_MASK  = 32'h0000_0004; // Interrupt mask, same layout as indicator
    localparam logic [31:0] IVC_ADDR_CTRL  = 32'h0000_0008; // Control: interrupt enable
    localparam logic [31:0] IVC_ADDR_STATE = 32'h0000_000c; // Read-only view of latches and triggers

    // Indicator register bit positions
    localparam int IVC_IND_OP_BIT    = 15; // Invalid operation code
    localparam int IVC_IND_AD_BIT    = 16; // Invalid address
    localparam int IVC_IND_STORE_BIT = 19; // Operand store error
    localparam int IVC_IND_FETCH_BIT = 20; // Operand fetch error

    // Implemented indicator bits; all others read as zero
    localparam logic [31:0] IVC_IND_IMPL = 32'h0019_8000;

    // Control register field and reset values
    localparam int IVC_CTRL_IEN_BIT = 0;
    localparam logic IVC_CTRL_IEN_RESET = 1'b1;
    localparam logic [31:0] IVC_IND_RESET = 32'h0000_0000;
    localparam logic [31:0] IVC_MASK_RESET = 32'h0000_0000;

    // Sampling cadence of the lookahead and indicator stages, in clocks
    localparam int IVC_SAMPLE_DIV = 4;

    // Number of distinct store and fetch error setting terms
    localparam int IVC_STORE_TERMS = 15;
    localparam int IVC_FETCH_TERMS = 14;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } ivc_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ivc_apb_rsp_t;

    // Decoded error conditions from the instruction and lookahead units
    typedef struct packed {
        logic iu_op_bad;          // Instruction unit decode found no valid operation
        logic vfl_op_bad;         // Variable field length operation invalid
        logic fp_op_bad;          // Floating point operation invalid
        logic io_op_bad;          // Input/output operation invalid
        logic vfl_addr_bad;       // Variable field length address nonexistent
        logic fp_addr_bad;        // Floating point address nonexistent
        logic io_addr_bad;        // Input/output address nonexistent
        logic iu_reg_addr_bad;    // Register address invalid in preparation
        logic iu_branch_addr_bad; // Branch address invalid in preparation
        logic iu_counter_addr_bad;// Counter address invalid in preparation
        logic vfl_fp_instr;       // Current instruction is variable field length or floating point
        logic instr_loc_bad;      // Location of the instruction itself does not exist
        logic left_addr_bad;      // Left half-word address nonexistent
        logic right_addr_bad;     // Right half-word address nonexistent
    } ivc_cond_t;

    // Whole state of the error block
    typedef struct packed {
        logic op_trig;
        logic lh_latch;
        logic rh_latch;
        logic addr_trig;
        logic st_latch;
        logic st_trig;
        logic ft_latch;
        logic ft_trig;
        logic ien;
        logic [31:0] ind;
        logic [31:0] mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } ivc_state_t;

endpackage

//--- rtl/ivc_sample_div.sv
// Divider that yields the one-cycle sampling enable for the error pipeline.
// Assumes the same clock and synchronous active-low reset as the main block.
module ivc_sample_div #(
    parameter int DIV = ivc_pkg::IVC_SAMPLE_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Sampling enable
    output logic tick
);
    import ivc_pkg::*;

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    // Divider state: count plus registered pulse
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } ivc_div_state_t;

    ivc_div_state_t s;      // Current state
    ivc_div_state_t next_s; // Next state

    // Count up to the last value, then pulse and wrap
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.cnt == LAST) begin
            next_s.cnt = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + CW'(1);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule

//--- rtl/ivc_err_unit.sv
// Error detection and indication for invalid operation codes, invalid
// addresses and operand store or fetch errors, with an APB register file.
// Assumes all condition inputs come from logic on clk; APB master on clk.
//
// Function
// - Sampled op-code trigger sets indicator bit 15
// - Op-code trigger set by decode, VARIABLE_FIELD_LENGTH, FP, I/O
// - Sampled address trigger sets indicator bit 16
// - Lookahead address trigger set by VARIABLE_FIELD_LENGTH/FP/IO addresses
// - Register, branch, counter address errors set it too
// - Half latches need missing instruction location for VARIABLE_FIELD_LENGTH/FP
// - Operand store error latch set by store terms while interrupt enable is set
// - Store latch sampled into lookahead store trigger
// - Store trigger sampled into indicator bit 19
// - Fetch latch to trigger to indicator bit 20
module ivc_err_unit #(
    parameter int SAMPLE_DIV = ivc_pkg::IVC_SAMPLE_DIV,
    parameter int STORE_TERMS = ivc_pkg::IVC_STORE_TERMS,
    parameter int FETCH_TERMS = ivc_pkg::IVC_FETCH_TERMS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire ivc_pkg::ivc_apb_req_t apb_req,
    output ivc_pkg::ivc_apb_rsp_t apb_rsp,
    // Error conditions from the instruction and lookahead units
    input wire ivc_pkg::ivc_cond_t cond,
    input wire logic [STORE_TERMS-1:0] store_terms,
    input wire logic [FETCH_TERMS-1:0] fetch_terms,
    // Indication
    output logic [31:0] indicator,
    output logic irq
);
    import ivc_pkg::*;

    ivc_state_t s;      // Current state
    ivc_state_t next_s; // Next state
    logic tick;         // Sampling enable from the divider

    // Combinational helpers
    logic setup;              // APB setup cycle
    logic access;             // APB access completes at this edge
    logic wr;                 // Write completes at this edge
    logic mapped;             // Setup address hits a register
    logic [31:0] rd_mux;      // Read data chosen in setup
    logic [31:0] ind_clr;     // Write-one-to-clear bits
    logic [31:0] ind_set;     // Bits set by sampling
    logic op_set;             // Op-code trigger setting term
    logic lh_set;             // Left half latch setting term
    logic rh_set;             // Right half latch setting term
    logic addr_set;           // Address trigger direct setting term
    logic st_set;             // Store latch setting term
    logic ft_set;             // Fetch latch setting term

    // Sampling cadence shared by lookahead and indicator stages
    ivc_sample_div #(
        .DIV(SAMPLE_DIV)
    ) u_div (
        .clk(clk),
        .rst_b(rst_b),
        .tick(tick)
    );

    // Setting terms of the instruction-unit latches and lookahead triggers
    always_comb begin
        // Decode plus the three execution families all raise the op-code trigger
        op_set = cond.iu_op_bad | cond.vfl_op_bad | cond.fp_op_bad | cond.io_op_bad;
        // For VARIABLE_FIELD_LENGTH/FP the half latches only arm when the instruction location is missing
        lh_set = cond.left_addr_bad & (~cond.vfl_fp_instr | cond.instr_loc_bad);
        rh_set = cond.right_addr_bad & (~cond.vfl_fp_instr | cond.instr_loc_bad);
        // Execution-family address faults go straight to the lookahead trigger
        addr_set = cond.vfl_addr_bad | cond.fp_addr_bad | cond.io_addr_bad;
        // Preparation-time address faults join the same trigger
        addr_set = addr_set | cond.iu_reg_addr_bad | cond.iu_branch_addr_bad
            | cond.iu_counter_addr_bad;
        // Every store term is gated by interrupt enable
        st_set = s.ien & (|store_terms);
        // Fetch terms carry the same enable gate
        ft_set = s.ien & (|fetch_terms);
    end

    // APB decode; answers are prepared in the setup cycle
    always_comb begin
        setup = apb_req.psel & ~apb_req.penable;
        access = apb_req.psel & apb_req.penable & s.pready;
        wr = access & apb_req.pwrite;
        mapped = 1'b1;
        case (apb_req.paddr)
            IVC_ADDR_IND: begin
                rd_mux = s.ind;
            end
            IVC_ADDR_MASK: begin
                rd_mux = s.mask;
            end
            IVC_ADDR_CTRL: begin
                rd_mux = {31'h0000_0000, s.ien};
            end
            IVC_ADDR_STATE: begin
                rd_mux = {23'h00_0000, s.ien, s.ft_trig, s.ft_latch, s.st_trig, s.st_latch,
                    s.addr_trig, s.rh_latch, s.lh_latch, s.op_trig};
            end
            default: begin
                // Unmapped: read zero and flag an error
                rd_mux = 32'h0000_0000;
                mapped = 1'b0;
            end
        endcase
        if (wr && apb_req.paddr == IVC_ADDR_IND) begin
            ind_clr = apb_req.pwdata & IVC_IND_IMPL;
        end else begin
            ind_clr = 32'h0000_0000;
        end
    end

    // Indicator bits captured from the lookahead triggers at each sample
    always_comb begin
        ind_set = 32'h0000_0000;
        if (tick) begin
            ind_set[IVC_IND_OP_BIT] = s.op_trig;
            ind_set[IVC_IND_AD_BIT] = s.addr_trig;
            ind_set[IVC_IND_STORE_BIT] = s.st_trig;
            ind_set[IVC_IND_FETCH_BIT] = s.ft_trig;
        end
    end

    // Next state; every sticky bit lets a new set win over a same-cycle clear
    always_comb begin
        next_s = s;
        // Op-code trigger holds until sampled into the indicator
        next_s.op_trig = (s.op_trig & ~tick) | op_set;
        // Half latches feed the address trigger at the sample point
        next_s.lh_latch = (s.lh_latch & ~tick) | lh_set;
        next_s.rh_latch = (s.rh_latch & ~tick) | rh_set;
        next_s.addr_trig = (s.addr_trig & ~tick) | addr_set
            | (tick & (s.lh_latch | s.rh_latch));
        // Store chain: latch, then lookahead trigger, one sample apart
        next_s.st_latch = (s.st_latch & ~tick) | st_set;
        next_s.st_trig = (s.st_trig & ~tick) | (tick & s.st_latch);
        // Fetch chain mirrors the store chain
        next_s.ft_latch = (s.ft_latch & ~tick) | ft_set;
        next_s.ft_trig = (s.ft_trig & ~tick) | (tick & s.ft_latch);
        // Indicator: set beats write-one-to-clear
        next_s.ind = ((s.ind & ~ind_clr) | ind_set) & IVC_IND_IMPL;
        // Software writes to mask and control
        if (wr && apb_req.paddr == IVC_ADDR_MASK) begin
            next_s.mask = apb_req.pwdata & IVC_IND_IMPL;
        end
        if (wr && apb_req.paddr == IVC_ADDR_CTRL) begin
            next_s.ien = apb_req.pwdata[IVC_CTRL_IEN_BIT];
        end
        // Bus answer: one access cycle, no wait states
        next_s.pready = setup;
        if (setup) begin
            next_s.prdata = rd_mux;
            next_s.pslverr = ~mapped;
        end else begin
            next_s.prdata = 32'h0000_0000;
            next_s.pslverr = 1'b0;
        end
        // Level interrupt computed from the next values so it tracks the bits exactly
        next_s.irq = |(next_s.ind & next_s.mask);
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s <= '0;
            s.ien <= IVC_CTRL_IEN_RESET;
            s.ind <= IVC_IND_RESET;
            s.mask <= IVC_MASK_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flip-flops
    assign apb_rsp.prdata = s.prdata;
    assign apb_rsp.pready = s.pready;
    assign apb_rsp.pslverr = s.pslverr;
    assign indicator = s.ind;
    assign irq = s.irq;

    // Checks on the error pipeline
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_op_to_ind: assert property (
        s.op_trig && tick |=> s.ind[IVC_IND_OP_BIT]
    ) else $error("op-code trigger not carried to indicator");

    a_op_set_terms: assert property (
        (cond.vfl_op_bad || cond.fp_op_bad || cond.io_op_bad || cond.iu_op_bad) |=> s.op_trig
    ) else $error("op-code condition did not set trigger");

    a_addr_to_ind: assert property (
        s.addr_trig && tick |=> s.ind[IVC_IND_AD_BIT]
    ) else $error("address trigger not carried to indicator");

    a_addr_exec_set: assert property (
        (cond.vfl_addr_bad || cond.io_addr_bad || cond.fp_addr_bad) |=> s.addr_trig
    ) else $error("execution address fault did not set trigger");

    a_addr_prep_set: assert property (
        (cond.iu_reg_addr_bad || cond.iu_branch_addr_bad || cond.iu_counter_addr_bad) |=> s.addr_trig
    ) else $error("preparation address fault did not set trigger");

    a_half_gate: assert property (
        $rose(s.lh_latch) || $rose(s.rh_latch) |-> $past(!cond.vfl_fp_instr || cond.instr_loc_bad)
    ) else $error("half latch set for VARIABLE_FIELD_LENGTH/FP with valid instruction location");

    a_store_latch: assert property (
        s.ien && (|store_terms) |=> s.st_latch
    ) else $error("store terms did not set store latch");

    a_store_chain: assert property (
        s.st_latch && tick |=> s.st_trig ##[1:8] s.ind[IVC_IND_STORE_BIT]
    ) else $error("store latch not passed through the chain");

    a_store_ind: assert property (
        s.st_trig && tick |=> s.ind[IVC_IND_STORE_BIT]
    ) else $error("store trigger not carried to indicator");

    a_fetch_chain: assert property (
        s.ft_latch && tick |=> s.ft_trig ##[1:8] s.ind[IVC_IND_FETCH_BIT]
    ) else $error("fetch error not carried to indicator");

    a_store_gate: assert property (
        $rose(s.st_latch) |-> $past(s.ien)
    ) else $error("store latch set while interrupts disabled");

    a_irq_level: assert property (
        irq == |(s.ind & s.mask)
    ) else $error("interrupt level disagrees with unmasked bits");

    // Main scenarios
    c_op_indicated: cover property (s.op_trig && tick ##1 s.ind[IVC_IND_OP_BIT]);
    c_store_full: cover property (s.st_latch ##[1:8] s.st_trig ##[1:8] s.ind[IVC_IND_STORE_BIT]);
    c_clear_vs_set: cover property (ind_clr[IVC_IND_AD_BIT] && ind_set[IVC_IND_AD_BIT]);
    c_irq_raised: cover property ($rose(irq));
endmodule

//--- verification/ivc_err_unit_test.sv
// Self-checking bench for the error indication block: reset values, a table of
// single-cycle error conditions, then interrupt, gating, mid-run reset and bus refusal cases.
// Assumes the design package and ivc_err_unit are compiled before this file.
module ivc_err_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ivc_pkg::*;

    // Short sampling cadence keeps each row quick
    localparam int DIV = 2;

    // One table row: conditions, store terms, fetch terms, expected indicator
    typedef struct packed {
        logic [13:0] c;
        logic [14:0] s;
        logic [13:0] f;
        logic [31:0] e;
    } ivc_row_t;

    // Design ports
    logic clk;
    logic rst_b;
    ivc_apb_req_t apb_req;
    ivc_apb_rsp_t apb_rsp;
    ivc_cond_t cond;
    logic [IVC_STORE_TERMS-1:0] store_terms;
    logic [IVC_FETCH_TERMS-1:0] fetch_terms;
    logic [31:0] indicator;
    logic irq;

    // Bench bookkeeping
    int bad_count;
    int checks;
    logic [31:0] rd;
    logic err;

    // Cond bits: 13 op decode .. 10 io op, 9..4 address, 3 vfl/fp, 2 loc bad, 1 left, 0 right
    ivc_row_t rows [0:15] = '{
        '{14'h2000, 15'h0000, 14'h0000, 32'h0000_8000},
        '{14'h1000, 15'h0000, 14'h0000, 32'h0000_8000},
        '{14'h0800, 15'h0000, 14'h0000, 32'h0000_8000},
        '{14'h0400, 15'h0000, 14'h0000, 32'h0000_8000},
        '{14'h0200, 15'h0000, 14'h0000, 32'h0001_0000},
        '{14'h0100, 15'h0000, 14'h0000, 32'h0001_0000},
        '{14'h0080, 15'h0000, 14'h0000, 32'h0001_0000},
        '{14'h0040, 15'h0000, 14'h0000, 32'h0001_0000},
        '{14'h0020, 15'h0000, 14'h0000, 32'h0001_0000},
        '{14'h0010, 15'h0000, 14'h0000, 32'h0001_0000},
        '{14'h0002, 15'h0000, 14'h0000, 32'h0001_0000},
        '{14'h000d, 15'h0000, 14'h0000, 32'h0001_0000},
        '{14'h000a, 15'h0000, 14'h0000, 32'h0000_0000},
        '{14'h0000, 15'h0001, 14'h0000, 32'h0008_0000},
        '{14'h0000, 15'h4000, 14'h0000, 32'h0008_0000},
        '{14'h0000, 15'h0000, 14'h2001, 32'h0010_0000}
    };

    // Device under test
    ivc_err_unit #(.SAMPLE_DIV(DIV)) uut (
        .clk(clk),
        .rst_b(rst_b),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .cond(cond),
        .store_terms(store_terms),
        .fetch_terms(fetch_terms),
        .indicator(indicator),
        .irq(irq)
    );

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    // Compare and count; four-state equality so unknowns never match
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One APB transfer; waits for pready with a bound rather than assuming latency
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= w;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        r = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        if (n >= 20) begin
            chk(32'h0, 32'h1, "pready wait");
        end
    endtask

    // Single-cycle condition pulse, then enough ticks for the two-stage paths
    task automatic pulse(input logic [13:0] c, input logic [14:0] s, input logic [13:0] f);
        @(posedge clk);
        cond <= ivc_cond_t'(c);
        store_terms <= s;
        fetch_terms <= f;
        @(posedge clk);
        cond <= '0;
        store_terms <= '0;
        fetch_terms <= '0;
        #1;
        chk(indicator, 32'h0, "indicator before sampling");
        repeat (6 * DIV + 4) @(posedge clk);
        #1;
    endtask

    // Hang guard: the whole run needs well under 2000 cycles
    initial begin
        #100000;
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        apb_req = '0;
        cond = '0;
        store_terms = '0;
        fetch_terms = '0;
        bad_count = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;

        // Reset values of every register
        apb(1'b0, IVC_ADDR_IND, 32'h0, rd, err);
        chk(rd, IVC_IND_RESET, "ind reset");
        apb(1'b0, IVC_ADDR_MASK, 32'h0, rd, err);
        chk(rd, IVC_MASK_RESET, "mask reset");
        apb(1'b0, IVC_ADDR_CTRL, 32'h0, rd, err);
        chk(rd, {31'h0, IVC_CTRL_IEN_RESET}, "ctrl reset");
        apb(1'b0, IVC_ADDR_STATE, 32'h0, rd, err);
        chk(rd, 32'h0000_0100, "state reset");
        $display("reset test done");

        // Table: each source reaches its indicator bit, except the gated VARIABLE_FIELD_LENGTH/FP half-latch row, which sets none; then W1C clears
        for (int i = 0; i < 16; i++) begin
            pulse(rows[i].c, rows[i].s, rows[i].f);
            chk(indicator, rows[i].e, "indicator");
            chk({31'h0, irq}, 32'h0, "irq masked");
            apb(1'b0, IVC_ADDR_STATE, 32'h0, rd, err);
            chk(rd, 32'h0000_0100, "latches consumed");
            apb(1'b1, IVC_ADDR_IND, IVC_IND_IMPL, rd, err);
            apb(1'b0, IVC_ADDR_IND, 32'h0, rd, err);
            chk(rd, 32'h0, "ind cleared");
            $display("row %0d done", i);
        end

        // Interrupt: raised when unmasked, dropped by mask, then by clear
        apb(1'b1, IVC_ADDR_MASK, IVC_IND_IMPL, rd, err);
        apb(1'b0, IVC_ADDR_MASK, 32'h0, rd, err);
        chk(rd, IVC_IND_IMPL, "mask readback");
        pulse(14'h0, 15'h0100, 14'h0);
        chk({31'h0, irq}, 32'h1, "irq raised");
        apb(1'b1, IVC_ADDR_MASK, 32'h0, rd, err);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0, "irq masked off");
        apb(1'b1, IVC_ADDR_MASK, IVC_IND_IMPL, rd, err);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        apb(1'b1, IVC_ADDR_IND, 32'h0008_0000, rd, err);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        chk(indicator, 32'h0, "ind after clear");
        $display("interrupt test done");

        // Interrupts disabled: store and fetch terms must be ignored
        apb(1'b1, IVC_ADDR_CTRL, 32'h0, rd, err);
        pulse(14'h0, 15'h7fff, 14'h3fff);
        chk(indicator, 32'h0, "ind with ien low");
        apb(1'b0, IVC_ADDR_STATE, 32'h0, rd, err);
        chk(rd, 32'h0, "state with ien low");
        apb(1'b1, IVC_ADDR_CTRL, 32'h1, rd, err);
        $display("gating test done");

        // Mid-run reset: sticky bit, interrupt, mask and enable all return to reset values
        apb(1'b1, IVC_ADDR_CTRL, 32'h0, rd, err);
        pulse(14'h2000, 15'h0, 14'h0);
        chk(indicator, 32'h0000_8000, "ind before reset");
        chk({31'h0, irq}, 32'h1, "irq before reset");
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk(indicator, IVC_IND_RESET, "ind after reset");
        chk({31'h0, irq}, 32'h0, "irq after reset");
        apb(1'b0, IVC_ADDR_CTRL, 32'h0, rd, err);
        chk(rd, {31'h0, IVC_CTRL_IEN_RESET}, "ctrl after reset");
        apb(1'b0, IVC_ADDR_MASK, 32'h0, rd, err);
        chk(rd, IVC_MASK_RESET, "mask after reset");
        $display("mid-run reset test done");

        // Bus refusals: unmapped address errors, state is read-only
        apb(1'b0, 32'h0000_0010, 32'h0, rd, err);
        chk(rd, 32'h0, "unmapped data");
        chk({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b1, IVC_ADDR_STATE, 32'h0000_00ff, rd, err);
        chk({31'h0, err}, 32'h0, "state write error");
        apb(1'b0, IVC_ADDR_STATE, 32'h0, rd, err);
        chk(rd, 32'h0000_0100, "state unchanged");
        $display("bus test done");

        print_verdict();
    end
endmodule
